// ===== hdl/sefe_pkg.sv
// Purpose: Constants and types for the serial EEPROM two-wire front end.
// Assumes: 250 MHz system clock; bus clock and data sampled as pins.
// Notes: Operation
// Operation
// - Ignore all bus activity during reset; enter standby on release.
// - Each self-timed programming cycle ends within 5 ms.
// - Data changes only while clock low; else start or stop.
// - Driven data held a minimum delay after each falling clock.
// - Array organised as 32-byte pages; 64 to 512 pages.
// - Two configuration registers: write protection and slave address.
// - Once locked, configuration registers are read-only.
// - Write protection register selects which array writes are accepted.
// - Transaction opens with address byte: type id, address, direction.
// - Compare three address bits against the slave address register.
// - Accept only the supported type identifier in upper four bits.
// - Respond only to the supported type id with matching address bits.
// - Address bit 0 one means read, zero means write.
// - Mismatched address byte is not acknowledged; back to standby.
// - Two word-address bytes follow; bit 7 selects configuration.
// - No acknowledge while a programming cycle is in progress.
package sefe_pkg;
  localparam int CLK_MHZ = 250;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYCLES = PROG_TIME_MS * 1000 * CLK_MHZ;
  localparam int HOLD_TIME_NS = 300;
  localparam int HOLD_CYCLES = (HOLD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_BITS = 5;
  localparam logic [3:0] TYPE_ID = 4'hA;
  localparam int TYPE_POS = 4;
  localparam int HWA_POS = 1;
  localparam int DIR_POS = 0;
  localparam int CFG_SEL_POS = 7;
  localparam int WP_MODE_POS = 0;
  localparam logic [2:0] HWA_RESET = 3'h0;
  localparam logic [7:0] WPR_RESET = 8'h00;
  localparam logic [1:0] WP_NONE = 2'h0;
  localparam logic [1:0] WP_UPPER = 2'h1;
  localparam logic [1:0] WP_HALF = 2'h2;
  localparam logic [1:0] WP_ALL = 2'h3;
  typedef enum logic [3:0] {
    SEFE_IDLE, SEFE_DEV, SEFE_DEV_ACK, SEFE_WA1, SEFE_WA1_ACK,
    SEFE_WA2, SEFE_WA2_ACK, SEFE_WDATA, SEFE_WDATA_ACK,
    SEFE_RDATA, SEFE_RDATA_ACK
  } sefe_state_t;
endpackage

// ===== hdl/sefe_front_end.sv
// Purpose: Two-wire slave front end of a serial EEPROM.
// Assumes: Bus pins cross into clk_in by two flip-flops each.
// Notes: Array storage and nonvolatile lock cell sit outside this block.
`timescale 1ns/10ps
module sefe_front_end #(
  parameter int ADDR_W = 14,
  parameter int PROG_CYCLES = sefe_pkg::PROG_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic cfg_locked_in,
  output logic cfg_lock_set_out,
  output logic [7:0] write_protect_config_reg_out,
  output logic [2:0] hw_slave_addr_config_reg_out,
  output logic mem_wr_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  input wire logic [7:0] mem_rdata_in,
  output logic busy_out,
  output logic addressed_out,
  output logic [1:0] protect_mode_out
);
  localparam int PAGE_N = 1 << (ADDR_W - sefe_pkg::PAGE_BITS);
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic scl_d1_q;
  logic sda_d1_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  sefe_pkg::sefe_state_t st_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic rd_q;
  logic cfg_sel_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] wpr_q;
  logic [2:0] har_q;
  logic [7:0] pend_wpr_q;
  logic [2:0] pend_har_q;
  logic pend_cfg_q;
  logic byte_done_q;
  logic wr_seen_q;
  logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt_q;
  logic prog_q;
  logic [$clog2(sefe_pkg::HOLD_CYCLES+1)-1:0] hold_q;
  logic drive_low_q;
  logic drive_low_d;
  logic dev_match;
  logic wr_allowed;

  always_ff @(posedge clk_in) begin
    scl_s_q <= {scl_s_q[0], scl_in};
    sda_s_q <= {sda_s_q[0], sda_in};
    scl_d1_q <= scl_s_q[1];
    sda_d1_q <= sda_s_q[1];
    if (rst_in) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end
  end

  assign scl_rise = scl_s_q[1] && !scl_d1_q;
  assign scl_fall = !scl_s_q[1] && scl_d1_q;
  // Data edge with clock high is a bus condition, not data
  assign start_det = scl_s_q[1] && scl_d1_q && sda_d1_q && !sda_s_q[1];
  assign stop_det = scl_s_q[1] && scl_d1_q && !sda_d1_q && sda_s_q[1];

  assign dev_match = (sh_q[7:sefe_pkg::TYPE_POS] == sefe_pkg::TYPE_ID)
    && (sh_q[sefe_pkg::TYPE_POS-1:sefe_pkg::HWA_POS] == har_q);

  // Protection by address fraction of the page space
  always_comb begin
    wr_allowed = 1'b1;
    case (wpr_q[sefe_pkg::WP_MODE_POS+:2])
      sefe_pkg::WP_NONE: wr_allowed = 1'b1;
      sefe_pkg::WP_UPPER: wr_allowed = !(&addr_q[ADDR_W-1 -: 2]);
      sefe_pkg::WP_HALF: wr_allowed = !addr_q[ADDR_W-1];
      sefe_pkg::WP_ALL: wr_allowed = 1'b0;
      default: wr_allowed = 1'b0;
    endcase
  end

  // Flags a whole byte, so the fall after an ack clock is not taken as one
  always_ff @(posedge clk_in) begin
    if (rst_in || start_det || stop_det) begin
      byte_done_q <= 1'b0;
    end else if (scl_rise && bit_q == 3'h7
        && st_q inside {sefe_pkg::SEFE_DEV, sefe_pkg::SEFE_WA1,
        sefe_pkg::SEFE_WA2, sefe_pkg::SEFE_WDATA, sefe_pkg::SEFE_RDATA}) begin
      byte_done_q <= 1'b1;
    end else if (scl_fall) begin
      byte_done_q <= 1'b0;
    end
  end

  // Programming follows only a write that carried at least one data byte
  always_ff @(posedge clk_in) begin
    if (rst_in || start_det) begin
      wr_seen_q <= 1'b0;
    end else if (scl_fall && byte_done_q
        && st_q == sefe_pkg::SEFE_WDATA) begin
      wr_seen_q <= 1'b1;
    end
  end

  // Byte and state sequencing on the synchronised bus clock
  always_ff @(posedge clk_in) begin
    mem_wr_out <= 1'b0;
    if (rst_in) begin
      st_q <= sefe_pkg::SEFE_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      cfg_sel_q <= 1'b0;
      addr_q <= '0;
      mem_wdata_out <= 8'h00;
      pend_wpr_q <= sefe_pkg::WPR_RESET;
      pend_har_q <= sefe_pkg::HWA_RESET;
      pend_cfg_q <= 1'b0;
    end else if (start_det) begin
      st_q <= sefe_pkg::SEFE_DEV;
      bit_q <= 3'h0;
    end else if (stop_det) begin
      st_q <= sefe_pkg::SEFE_IDLE;
    end else if (scl_rise) begin
      case (st_q)
        sefe_pkg::SEFE_DEV, sefe_pkg::SEFE_WA1, sefe_pkg::SEFE_WA2,
        sefe_pkg::SEFE_WDATA: begin
          sh_q <= {sh_q[6:0], sda_s_q[1]};
          bit_q <= bit_q + 3'h1;
        end
        sefe_pkg::SEFE_RDATA: begin
          bit_q <= bit_q + 3'h1;
        end
        sefe_pkg::SEFE_RDATA_ACK: begin
          // Master not acknowledging ends the read
          if (sda_s_q[1]) begin
            st_q <= sefe_pkg::SEFE_IDLE;
          end else begin
            st_q <= sefe_pkg::SEFE_RDATA;
            addr_q <= addr_q + 1'b1;
          end
        end
        sefe_pkg::SEFE_DEV_ACK: begin
          st_q <= rd_q ? sefe_pkg::SEFE_RDATA : sefe_pkg::SEFE_WA1;
        end
        sefe_pkg::SEFE_WA1_ACK: st_q <= sefe_pkg::SEFE_WA2;
        sefe_pkg::SEFE_WA2_ACK: st_q <= sefe_pkg::SEFE_WDATA;
        sefe_pkg::SEFE_WDATA_ACK: begin
          st_q <= sefe_pkg::SEFE_WDATA;
          // Address rolls within the 32-byte page, after the write pulse
          addr_q[sefe_pkg::PAGE_BITS-1:0] <=
            addr_q[sefe_pkg::PAGE_BITS-1:0] + 1'b1;
        end
        default: st_q <= sefe_pkg::SEFE_IDLE;
      endcase
    end else if (scl_fall && byte_done_q) begin
      case (st_q)
        sefe_pkg::SEFE_DEV: begin
          if (dev_match && !prog_q) begin
            st_q <= sefe_pkg::SEFE_DEV_ACK;
            rd_q <= sh_q[sefe_pkg::DIR_POS];
          end else begin
            st_q <= sefe_pkg::SEFE_IDLE;
          end
        end
        sefe_pkg::SEFE_WA1: begin
          st_q <= sefe_pkg::SEFE_WA1_ACK;
          cfg_sel_q <= sh_q[sefe_pkg::CFG_SEL_POS];
          addr_q[ADDR_W-1:8] <= sh_q[ADDR_W-9:0];
        end
        sefe_pkg::SEFE_WA2: begin
          st_q <= sefe_pkg::SEFE_WA2_ACK;
          addr_q[7:0] <= sh_q;
        end
        sefe_pkg::SEFE_WDATA: begin
          st_q <= sefe_pkg::SEFE_WDATA_ACK;
          if (cfg_sel_q) begin
            if (!cfg_locked_in) begin
              if (addr_q[0]) begin
                pend_har_q <= sh_q[2:0];
              end else begin
                pend_wpr_q <= sh_q;
              end
              pend_cfg_q <= 1'b1;
            end
          end else if (wr_allowed) begin
            mem_wr_out <= 1'b1;
            mem_wdata_out <= sh_q;
          end
        end
        sefe_pkg::SEFE_RDATA: st_q <= sefe_pkg::SEFE_RDATA_ACK;
        default: ;
      endcase
    end
    if (!rst_in && stop_det) begin
      pend_cfg_q <= 1'b0;
    end
  end

  // Config registers commit at stop; lock comes from the nonvolatile cell
  always_ff @(posedge clk_in) begin
    cfg_lock_set_out <= 1'b0;
    if (rst_in) begin
      wpr_q <= sefe_pkg::WPR_RESET;
      har_q <= sefe_pkg::HWA_RESET;
    end else if (stop_det && pend_cfg_q && !cfg_locked_in) begin
      wpr_q <= pend_wpr_q;
      har_q <= pend_har_q;
      cfg_lock_set_out <= pend_wpr_q[7];
    end
  end

  // Self-timed programming cycle after a stop that ends a write
  // The stop's own clock pulse leaves one bit of a next byte counted
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prog_q <= 1'b0;
      prog_cnt_q <= '0;
    end else if (prog_q) begin
      if (prog_cnt_q == '0) begin
        prog_q <= 1'b0;
      end else begin
        prog_cnt_q <= prog_cnt_q - 1'b1;
      end
    end else if (stop_det && wr_seen_q && (st_q == sefe_pkg::SEFE_WDATA)
        && bit_q == 3'h1) begin
      prog_q <= 1'b1;
      prog_cnt_q <= $bits(prog_cnt_q)'(PROG_CYCLES - 1);
    end
  end

  always_comb begin
    drive_low_d = 1'b0;
    case (st_q)
      sefe_pkg::SEFE_DEV_ACK, sefe_pkg::SEFE_WA1_ACK,
      sefe_pkg::SEFE_WA2_ACK, sefe_pkg::SEFE_WDATA_ACK: drive_low_d = 1'b1;
      sefe_pkg::SEFE_RDATA: drive_low_d = !mem_rdata_in[3'h7 - bit_q];
      default: drive_low_d = 1'b0;
    endcase
  end

  // Output changes only after the hold delay past a falling clock
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hold_q <= '0;
      drive_low_q <= 1'b0;
    end else if (scl_fall) begin
      hold_q <= $bits(hold_q)'(sefe_pkg::HOLD_CYCLES);
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 1'b1;
      if (hold_q == 1) begin
        drive_low_q <= drive_low_d;
      end
    end else if (st_q == sefe_pkg::SEFE_IDLE) begin
      drive_low_q <= 1'b0;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = drive_low_q;
  assign write_protect_config_reg_out = wpr_q;
  assign hw_slave_addr_config_reg_out = har_q;
  assign mem_addr_out = addr_q;
  assign busy_out = prog_q;
  assign addressed_out = (st_q != sefe_pkg::SEFE_IDLE)
    && (st_q != sefe_pkg::SEFE_DEV);
  assign protect_mode_out = wpr_q[sefe_pkg::WP_MODE_POS+:2];
endmodule

// ===== tb/sefe_front_end_assertions.sv
// Purpose: Pin checks on the EEPROM front end.
// Assumes: scl_in is the raw pin.
// Notes: Counters time the busy span and the clock-low span.
`timescale 1ns/10ps
module sefe_front_end_assertions #(
  parameter int PROG_CYCLES = 200
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_oe_out,
  input wire logic busy_out,
  input wire logic mem_wr_out,
  input wire logic [1:0] protect_mode_out,
  input wire logic [7:0] write_protect_config_reg_out,
  input wire logic [2:0] hw_slave_addr_config_reg_out,
  input wire logic cfg_locked_in,
  input wire logic cfg_lock_set_out
);
  int busy_cnt_q;
  int low_cnt_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge clk_in) begin
    busy_cnt_q <= (rst_in || !busy_out) ? 0 : busy_cnt_q + 1;
  end
  always_ff @(posedge clk_in) begin
    low_cnt_q <= scl_in ? 0 : (low_cnt_q < 999 ? low_cnt_q + 1 : 999);
  end
  chk_reset_quiet: assert property (disable iff (1'b0)
    rst_in |=> !sda_oe_out && !busy_out &&
    hw_slave_addr_config_reg_out == sefe_pkg::HWA_RESET) else $error("rst");
  chk_busy_bound: assert property (busy_cnt_q <= PROG_CYCLES + 1)
    else $error("busy too long");
  chk_oe_hold: assert property ($changed(sda_oe_out) |->
    low_cnt_q >= sefe_pkg::HOLD_CYCLES) else $error("sda moved early");
  chk_no_ack_busy: assert property (busy_out |-> !sda_oe_out)
    else $error("ack while busy");
  chk_wr_protect: assert property (mem_wr_out |->
    protect_mode_out != sefe_pkg::WP_ALL) else $error("protected write");
  chk_mode_mirror: assert property (
    protect_mode_out == write_protect_config_reg_out[1:0]) else $error("mode");
  chk_cfg_commit: assert property (
    $changed(write_protect_config_reg_out) ||
    $changed(hw_slave_addr_config_reg_out) |-> $rose(busy_out))
    else $error("config changed outside a write cycle");
  chk_lock_frozen: assert property (
    cfg_locked_in && $past(cfg_locked_in) |->
    $stable(write_protect_config_reg_out) &&
    $stable(hw_slave_addr_config_reg_out)) else $error("locked reg changed");
  chk_lock_pulse: assert property (cfg_lock_set_out |->
    !cfg_locked_in ##1 !cfg_lock_set_out) else $error("lock request");
  cover property (mem_wr_out);
  cover property ($rose(busy_out));
  cover property (cfg_lock_set_out);
endmodule
bind sefe_front_end sefe_front_end_assertions #(.PROG_CYCLES(PROG_CYCLES))
  chk_inst (.clk_in, .rst_in, .scl_in, .sda_oe_out, .busy_out, .mem_wr_out,
  .protect_mode_out, .write_protect_config_reg_out,
  .hw_slave_addr_config_reg_out, .cfg_locked_in, .cfg_lock_set_out);

// ===== tb/sefe_bus_master.sv
// Purpose: Two-wire master driving SCL and pulling SDA.
// Assumes: 16 clocks a bit, a 64 ns link clock.
// Notes: Ack bits get long low phases for the slave hold delay.
`timescale 1ns/10ps
module sefe_bus_master (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out,
  output logic ack_valid_out,
  output logic ack_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
    ack_valid_out = 1'b0;
    ack_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic bit_out(input logic b, input int lo);
    sda_oe_out <= !b;
    tick(lo);
    scl_out <= 1'b1;
    tick(4);
    ack_out <= sda_in;
    tick(4);
    scl_out <= 1'b0;
    tick(4);
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_out(b[i], 4);
    bit_out(1'b1, 100);
    ack_valid_out <= 1'b1;
    tick(1);
    ack_valid_out <= 1'b0;
    tick(96);
  endtask
  task automatic recv_byte();
    for (int i = 0; i < 8; i++) begin
      bit_out(1'b1, 100);
      ack_valid_out <= 1'b1;
      tick(1);
      ack_valid_out <= 1'b0;
    end
    bit_out(1'b1, 100);
    tick(96);
  endtask
  task automatic start_cond();
    sda_oe_out <= 1'b0;
    tick(8);
    scl_out <= 1'b1;
    tick(8);
    sda_oe_out <= 1'b1;
    tick(8);
    scl_out <= 1'b0;
    tick(4);
  endtask
  task automatic stop_cond();
    sda_oe_out <= 1'b1;
    tick(8);
    scl_out <= 1'b1;
    tick(8);
    sda_oe_out <= 1'b0;
    tick(8);
  endtask
endmodule

// ===== tb/sefe_front_end_tb_top.sv
// Purpose: Self-checking bench for the EEPROM front end.
// Assumes: Pulled-up SDA; short programming cycle.
// Notes: Acks and array writes are matched against queues.
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %0t %h %h", $time, (a), (e)); end end
module sefe_front_end_tb_top;
  localparam int PROG = 2000;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic lck = 1'b0;
  logic scl, m_oe, oe, sdo, ack_v, ack, wr, busy, lock_set, adr;
  logic [7:0] write_protect_config_reg, wd;
  logic [2:0] hw_slave_addr_config_reg;
  logic [13:0] ma;
  logic [1:0] pm;
  logic [31:0] lfsr = 32'h1D1E3079;
  logic ack_q[$];
  logic [22:0] wr_q[$];
  logic [22:0] exp_wr;
  logic exp_ack;
  logic [7:0] rdat = 8'h00;
  int miscompares = 0;
  int checked = 0;
  int locks = 0;
  wire sda = !(m_oe || (oe && !sdo));
  sefe_front_end #(.ADDR_W(14), .PROG_CYCLES(PROG)) sefe_front_end_inst (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sdo), .sda_oe_out(oe), .cfg_locked_in(lck),
    .cfg_lock_set_out(lock_set), .write_protect_config_reg_out(write_protect_config_reg),
    .hw_slave_addr_config_reg_out(hw_slave_addr_config_reg), .mem_wr_out(wr), .mem_addr_out(ma),
    .mem_wdata_out(wd), .mem_rdata_in(rdat), .busy_out(busy),
    .addressed_out(adr), .protect_mode_out(pm));
  sefe_bus_master sefe_bus_master_inst (.clk_in(clk_in), .sda_in(sda),
    .scl_out(scl), .sda_oe_out(m_oe), .ack_valid_out(ack_v), .ack_out(ack));
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (ack_v) begin
      exp_ack = ack_q.pop_front();
      `CHK(ack, exp_ack)
    end
    if (wr) begin
      exp_wr = wr_q.pop_front();
      `CHK({1'b1, ma, wd}, exp_wr)
    end
    if (lock_set) locks++;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic stp();
    sefe_bus_master_inst.stop_cond();
  endtask
  task automatic xfer(input logic [7:0] b, input logic e);
    ack_q.push_back(e);
    sefe_bus_master_inst.send_byte(b);
  endtask
  task automatic sel(input logic [7:0] dev, input logic e);
    sefe_bus_master_inst.start_cond();
    xfer(dev, e);
  endtask
  task automatic rdb(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) ack_q.push_back(d[i]);
    sefe_bus_master_inst.recv_byte();
  endtask
  task automatic wrt(input logic [7:0] dv, w1, w2, dt, input logic e);
    sel(dv, 1'b0);
    xfer(w1, 1'b0);
    xfer(w2, 1'b0);
    xfer(dt, e);
    stp();
  endtask
  task automatic idle();
    repeat (PROG + 10) if (busy !== 1'b0) tick(1);
    `CHK(busy, 1'b0)
  endtask
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic report_and_stop();
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    tick(4);
    rst_in <= 1'b0;
    tick(25000);
    `CHK(write_protect_config_reg, sefe_pkg::WPR_RESET)
    wrt(8'hA0, 8'h80, 8'h01, 8'h05, 1'b0);
    idle();
    `CHK(hw_slave_addr_config_reg, 3'h5)
    for (int i = 0; i < 8; i++) begin
      sel({sefe_pkg::TYPE_ID, i[2:0], 1'b0}, i != 5);
      `CHK(adr, i == 5)
      stp();
    end
    lfsr = step(lfsr);
    sel({lfsr[3:0] | 4'h1, 3'h5, 1'b0}, 1'b1);
    stp();
    lfsr = step(lfsr);
    wr_q.push_back({1'b1, 14'h0123, lfsr[7:0]});
    wrt(8'hAA, 8'h01, 8'h23, lfsr[7:0], 1'b0);
    `CHK(busy, 1'b1)
    sel(8'hAA, 1'b1);
    stp();
    idle();
    lfsr = step(lfsr);
    rdat <= lfsr[7:0];
    sel(8'hAB, 1'b0);
    rdb(lfsr[7:0]);
    stp();
    wrt(8'hAA, 8'h80, 8'h00, 8'h83, 1'b0);
    idle();
    `CHK(pm, sefe_pkg::WP_ALL)
    `CHK(locks, 1)
    lck <= 1'b1;
    wrt(8'hAA, 8'h00, 8'h10, 8'h5A, 1'b0);
    idle();
    wrt(8'hAA, 8'h80, 8'h01, 8'h02, 1'b0);
    idle();
    `CHK(hw_slave_addr_config_reg, 3'h5)
    sel(8'hAA, 1'b0);
    rst_in <= 1'b1;
    xfer(8'h80, 1'b1);
    stp();
    rst_in <= 1'b0;
    tick(4);
    `CHK(hw_slave_addr_config_reg, sefe_pkg::HWA_RESET)
    sel(8'hA0, 1'b0);
    stp();
    report_and_stop();
  end
  initial begin
    tick(80000);
    miscompares++;
    report_and_stop();
  end
endmodule
